// *** core/pssr_regs.sv ***
`timescale 1ns/1ps
module pssr_regs (
  input  wire logic                  mclk_in,          // 40 MHz clock
  input  wire logic                  arst_n_in,        // Async reset, low
  input  wire pssr_pkg::pssr_access_t acc_in,          // Decoded I2C access
  input  wire logic [6:0]            device_id_in,     // Own 7-bit address
  input  wire logic [7:0]            audio_cfg_in,     // Audio config reg
  input  wire logic                  aux_audio_in,     // Secondary audio on
  input  wire logic                  repeater_in,      // Repeater operation
  input  wire logic                  inband_ovr_en_in, // In-band override on
  input  wire logic                  inband_multi_in,  // In-band multichannel
  input  wire logic                  bist_active_in,   // Self test running
  input  wire logic                  bist_start_in,    // New run, pulse
  input  wire logic                  bc_err_clear_in,  // Counter clear, pulse
  input  wire logic                  bc_crc_err_in,    // CRC error, pulse
  input  wire pssr_pkg::pssr_pins_t  pins_in,          // Async pin levels
  output logic [7:0]                 rd_data_out,      // Read data, reg
  output logic                       rd_valid_out,     // Read data valid
  output pssr_pkg::pssr_steer_t      steer_out,        // Port steering
  output logic                       reg_hit_out,      // Local reg selected
  output logic                       wide_payload_select_out, // 28-bit mode
  output logic [4:0]                 payload_bits_out, // Data bit count
  output logic                       sync_ctrl_en_out, // Carry sync controls
  output pssr_pkg::pssr_audio_mode_t audio_mode_out,   // Audio channel mode
  output logic                       island_only_out,  // Island transport
  output logic                       second_address_enable_out // Second addr
);
  logic [7:0]          dp_ctrl;
  logic [7:0]          port_sel;
  logic [7:0]          backchannel_crc_errors;
  pssr_pkg::pssr_pins_t pins_meta;
  pssr_pkg::pssr_pins_t pins_sync;
  logic                multichannel;
  logic                wr_local;
  logic                rd_local;
  logic [7:0]          next_rd_data;

  // Pins are asynchronous; second stage is the only reader of the first
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins_in;
      pins_sync <= pins_meta;
    end
  end

  // Address decode and port steering
  always_comb begin
    steer_out.primary_hit = acc_in.slave_id == device_id_in;
    steer_out.second_hit  = port_sel[pssr_pkg::BIT_SECOND_ADDR] &&
                            acc_in.slave_id == 7'(device_id_in + 7'h1);
    steer_out.port0_wr = 1'b0;
    steer_out.port1_wr = 1'b0;
    steer_out.port1_rd = 1'b0;
    if (steer_out.second_hit) begin
      steer_out.port1_wr = acc_in.wr;
      steer_out.port1_rd = 1'b1;
    end else if (steer_out.primary_hit) begin
      if (port_sel[pssr_pkg::BIT_SECOND_ADDR]) begin
        steer_out.port0_wr = acc_in.wr;
      end else begin
        steer_out.port0_wr = acc_in.wr &&
          (port_sel[pssr_pkg::BIT_PRI_PORT_SEL] ||
           !port_sel[pssr_pkg::BIT_SEC_PORT_SEL]);
        steer_out.port1_wr = acc_in.wr &&
          port_sel[pssr_pkg::BIT_SEC_PORT_SEL];
        steer_out.port1_rd = port_sel[pssr_pkg::BIT_SEC_PORT_SEL];
      end
    end
  end

  // Shared registers: reachable from either address
  assign reg_hit_out = (steer_out.primary_hit || steer_out.second_hit) &&
                       acc_in.addr >= pssr_pkg::ADDR_DATAPATH_CTRL2 &&
                       acc_in.addr <= pssr_pkg::ADDR_PORT_SELECT;
  assign wr_local    = reg_hit_out && acc_in.wr;
  assign rd_local    = reg_hit_out && acc_in.rd;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dp_ctrl <= pssr_pkg::RST_DATAPATH_CTRL2;
    end else if (wr_local &&
                 acc_in.addr == pssr_pkg::ADDR_DATAPATH_CTRL2) begin
      dp_ctrl <= acc_in.wdata & 8'h03;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      port_sel <= pssr_pkg::RST_PORT_SELECT;
    end else if (wr_local && acc_in.addr == pssr_pkg::ADDR_PORT_SELECT) begin
      port_sel <= acc_in.wdata & 8'h07;
    end
  end

  // Clear wins over a same-cycle error: the error belongs to the old run
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      backchannel_crc_errors <= pssr_pkg::RST_BC_ERR_COUNT;
    end else if (bist_start_in || bc_err_clear_in) begin
      backchannel_crc_errors <= pssr_pkg::RST_BC_ERR_COUNT;
    end else if (bist_active_in && bc_crc_err_in &&
                 backchannel_crc_errors != pssr_pkg::ERR_COUNT_MAX) begin
      backchannel_crc_errors <= backchannel_crc_errors + 8'h01;
    end
  end

  always_comb begin
    next_rd_data = 8'h00;
    case (acc_in.addr)
      pssr_pkg::ADDR_DATAPATH_CTRL2: begin
        next_rd_data = {4'h0, aux_audio_in, 1'b0, dp_ctrl[1:0]};
      end
      pssr_pkg::ADDR_BC_ERR_COUNT: begin
        next_rd_data = backchannel_crc_errors;
      end
      pssr_pkg::ADDR_PIN_STATUS1: begin
        next_rd_data = {pins_sync.aux_pin_seven, pins_sync.aux_pin_six,
                        pins_sync.aux_pin_five, 1'b0,
                        pins_sync.io_pin};
      end
      pssr_pkg::ADDR_PIN_STATUS2: begin
        next_rd_data = {7'h00, pins_sync.aux_pin_eight};
      end
      pssr_pkg::ADDR_PORT_SELECT: begin
        next_rd_data = port_sel;
      end
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_local;
      if (rd_local) begin
        rd_data_out <= next_rd_data;
      end
    end
  end

  // Repeater override is on by default through inband_ovr_en_in
  assign multichannel = (repeater_in && inband_ovr_en_in) ?
                        inband_multi_in :
                        dp_ctrl[pssr_pkg::BIT_SURROUND];

  assign wide_payload_select_out = dp_ctrl[pssr_pkg::BIT_WIDE_PAYLOAD];
  assign payload_bits_out = wide_payload_select_out ?
    5'(pssr_pkg::PAYLOAD_WIDE) : 5'(pssr_pkg::PAYLOAD_NARROW);
  assign sync_ctrl_en_out = !wide_payload_select_out;

  always_comb begin
    if (multichannel) begin
      audio_mode_out = pssr_pkg::PSSR_AUDIO_SURROUND;
    end else if (audio_cfg_in[pssr_pkg::BIT_AUDIO_CFG_HI] ||
                 audio_cfg_in[pssr_pkg::BIT_AUDIO_CFG_LO]) begin
      audio_mode_out = pssr_pkg::PSSR_AUDIO_FOUR_CH;
    end else begin
      audio_mode_out = pssr_pkg::PSSR_AUDIO_TWO_CH;
    end
  end

  // No other surround transport exists
  assign island_only_out = multichannel;
  assign second_address_enable_out =
    port_sel[pssr_pkg::BIT_SECOND_ADDR];

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_err_at_max;
    bist_active_in && bc_crc_err_in && !bist_start_in && !bc_err_clear_in &&
    backchannel_crc_errors == pssr_pkg::ERR_COUNT_MAX;
  endsequence

  property p_count_saturate;
    s_err_at_max |=> backchannel_crc_errors == pssr_pkg::ERR_COUNT_MAX;
  endproperty
  a_count_saturate: assert property (p_count_saturate)
    else $error("error counter wrapped");

  property p_count_step;
    bist_active_in && bc_crc_err_in && !bist_start_in && !bc_err_clear_in &&
    backchannel_crc_errors != pssr_pkg::ERR_COUNT_MAX
    |=> backchannel_crc_errors == 8'($past(backchannel_crc_errors) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("error counter missed an error");

  property p_count_clear;
    bist_start_in || bc_err_clear_in |=> backchannel_crc_errors == 8'h00;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("error counter not cleared");

  property p_width;
    payload_bits_out == (wide_payload_select_out ? 5'h1C : 5'h18) &&
    sync_ctrl_en_out != wide_payload_select_out;
  endproperty
  a_width: assert property (p_width)
    else $error("payload width mismatch");

  property p_island;
    audio_mode_out == pssr_pkg::PSSR_AUDIO_SURROUND |-> island_only_out;
  endproperty
  a_island: assert property (p_island)
    else $error("surround without island transport");

  property p_override;
    repeater_in && inband_ovr_en_in |->
      (audio_mode_out == pssr_pkg::PSSR_AUDIO_SURROUND) == inband_multi_in;
  endproperty
  a_override: assert property (p_override)
    else $error("in-band override ignored");

  property p_ignore_sel;
    port_sel[pssr_pkg::BIT_SECOND_ADDR] && steer_out.primary_hit &&
    !steer_out.second_hit |-> !steer_out.port1_wr && !steer_out.port1_rd;
  endproperty
  a_ignore_sel: assert property (p_ignore_sel)
    else $error("port select used with second address on");

  property p_both_sel;
    steer_out.primary_hit && !port_sel[pssr_pkg::BIT_SECOND_ADDR] &&
    port_sel[1:0] == 2'b11 && acc_in.wr |->
      steer_out.port0_wr && steer_out.port1_wr && steer_out.port1_rd;
  endproperty
  a_both_sel: assert property (p_both_sel)
    else $error("both selects steered wrong");

  property p_reserved_status;
    rd_local && acc_in.addr == pssr_pkg::ADDR_PIN_STATUS1 |=>
      rd_valid_out && rd_data_out[4] == 1'b0;
  endproperty
  a_reserved_status: assert property (p_reserved_status)
    else $error("reserved status bit not zero");
endmodule

// *** core/pssr_pkg.sv ***
package pssr_pkg;
  localparam logic [7:0] ADDR_DATAPATH_CTRL2 = 8'h1A;
  localparam logic [7:0] ADDR_BC_ERR_COUNT   = 8'h1B;
  localparam logic [7:0] ADDR_PIN_STATUS1    = 8'h1C;
  localparam logic [7:0] ADDR_PIN_STATUS2    = 8'h1D;
  localparam logic [7:0] ADDR_PORT_SELECT    = 8'h1E;

  localparam logic [7:0] RST_DATAPATH_CTRL2  = 8'h01;
  localparam logic [7:0] RST_BC_ERR_COUNT    = 8'h00;
  localparam logic [7:0] RST_PORT_SELECT     = 8'h01;

  // Field positions
  localparam int BIT_SURROUND      = 0;
  localparam int BIT_WIDE_PAYLOAD  = 1;
  localparam int BIT_SEC_AUDIO     = 3;
  localparam int BIT_PRI_PORT_SEL  = 0;
  localparam int BIT_SEC_PORT_SEL  = 1;
  localparam int BIT_SECOND_ADDR   = 2;
  localparam int BIT_AUDIO_CFG_HI  = 3;
  localparam int BIT_AUDIO_CFG_LO  = 0;

  localparam logic [7:0] ERR_COUNT_MAX     = 8'hFF;
  localparam int         PAYLOAD_NARROW    = 24;
  localparam int         PAYLOAD_WIDE      = 28;

  typedef enum logic [1:0] {
    PSSR_AUDIO_TWO_CH,
    PSSR_AUDIO_FOUR_CH,
    PSSR_AUDIO_SURROUND
  } pssr_audio_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] slave_id;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pssr_access_t;

  typedef struct packed {
    logic port0_wr;
    logic port1_wr;
    logic port1_rd;
    logic primary_hit;
    logic second_hit;
  } pssr_steer_t;

  typedef struct packed {
    logic       aux_pin_eight;
    logic       aux_pin_seven;
    logic       aux_pin_six;
    logic       aux_pin_five;
    logic [3:0] io_pin;
  } pssr_pins_t;
endpackage

// *** verif/pssr_host.sv ***
`timescale 1ns/1ps
module pssr_host (
  input  wire logic             mclk_in,     // Register clock
  input  wire logic [7:0]       rd_data_in,  // Read data from device
  input  wire logic             rd_valid_in, // Read data valid
  output pssr_pkg::pssr_access_t acc_out     // Decoded bus access
);
  logic       rvalid;
  logic [7:0] rdata;
  initial acc_out = '0;
  // One byte per access, held across exactly one taking edge
  task automatic access(input logic wr, input logic [6:0] id,
                        input logic [7:0] a, input logic [7:0] wd);
    acc_out <= '{wr, !wr, id, a, wd};
    @(posedge mclk_in);
    // Released strobes drop to zero and other fields show inverted values, never the stale request
    acc_out <= '{1'b0, 1'b0, ~id, ~a, ~wd};
    #1;
    rvalid = rd_valid_in;
    rdata  = rd_data_in;
    @(posedge mclk_in);
  endtask
endmodule

// *** verif/port_select_status_registers_tb.sv ***
`timescale 1ns/1ps
module port_select_status_registers_tb;
  logic                       mclk_in = 1'b0;
  logic                       arst_n_in = 1'b0;
  pssr_pkg::pssr_access_t     acc_in;
  logic [6:0]                 device_id_in = 7'h01;
  logic [7:0]                 audio_cfg_in = 8'h00;
  logic                       aux_audio_in = 1'b0;
  logic                       repeater_in = 1'b0;
  logic                       inband_ovr_en_in = 1'b1;
  logic                       inband_multi_in = 1'b0;
  logic                       bist_active_in = 1'b0;
  logic                       bist_start_in = 1'b0;
  logic                       bc_err_clear_in = 1'b0;
  logic                       bc_crc_err_in = 1'b0;
  pssr_pkg::pssr_pins_t       pins_in = '0;
  logic [7:0]                 rd_data_out;
  logic                       rd_valid_out;
  pssr_pkg::pssr_steer_t      steer_out;
  logic                       reg_hit_out;
  logic                       wide_payload_select_out;
  logic [4:0]                 payload_bits_out;
  logic                       sync_ctrl_en_out;
  pssr_pkg::pssr_audio_mode_t audio_mode_out;
  logic                       island_only_out;
  logic                       second_address_enable_out;
  logic [2:0]                 sel = 3'h1;
  logic [1:0]                 ctl = 2'h1;
  logic [7:0]                 wv;
  int                         n_mismatch = 0;
  int                         comparisons = 0;
  int                         cnt;
  int                         am;

  initial forever #12.5 mclk_in = ~mclk_in;

  pssr_regs i_dut (.mclk_in, .arst_n_in, .acc_in, .device_id_in,
    .audio_cfg_in, .aux_audio_in, .repeater_in, .inband_ovr_en_in,
    .inband_multi_in, .bist_active_in, .bist_start_in, .bc_err_clear_in,
    .bc_crc_err_in, .pins_in, .rd_data_out, .rd_valid_out, .steer_out,
    .reg_hit_out, .wide_payload_select_out, .payload_bits_out,
    .sync_ctrl_en_out, .audio_mode_out, .island_only_out,
    .second_address_enable_out);

  pssr_host i_host (.mclk_in(mclk_in), .rd_data_in(rd_data_out),
    .rd_valid_in(rd_valid_out), .acc_out(acc_in));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [6:0] id, input logic [7:0] a,
                    input int v, input logic [7:0] e, input string n);
    i_host.access(1'b0, id, a, 8'h00);
    chk({n, " valid"}, 8'(v), {7'h00, i_host.rvalid});
    if (v != 0) chk(n, e, i_host.rdata);
  endtask

  function automatic logic [5:0] exp_route();
    logic p;
    logic s;
    p = acc_in.slave_id == device_id_in;
    s = sel[2] && acc_in.slave_id == device_id_in + 7'h01;
    return {(p || s) && acc_in.addr >= 8'h1A && acc_in.addr <= 8'h1E,
      acc_in.wr && p && (sel[2] || sel[0] || !sel[1]),
      acc_in.wr && (s || p && !sel[2] && sel[1]),
      s || p && !sel[2] && sel[1], p, s};
  endfunction

  // Steering is combinational, so look mid-cycle while a request stands
  always @(negedge mclk_in) begin
    if (acc_in.wr || acc_in.rd) begin
      chk("route", 8'(exp_route()),
        {2'b00, reg_hit_out, steer_out});
    end
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    n_mismatch++;
    results();
  end

  initial begin
    void'($urandom(93));
    repeat (10) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    device_id_in <= 7'($urandom_range(126, 1));
    aux_audio_in <= 1'($urandom);
    @(posedge mclk_in);
    rd(device_id_in, 8'h1A, 1, {4'h0, aux_audio_in, 3'b001}, "ctl2");
    rd(device_id_in, 8'h1B, 1, 8'h00, "errcnt");
    rd(device_id_in, 8'h1E, 1, 8'h01, "portsel");
    rd(device_id_in, 8'h1F, 0, 8'h00, "unmapped");
    // Upper half disables the in-band override; bit 2 of k runs the repeater
    for (int k = 0; k < 16; k++) begin
      ctl = 2'(k);
      audio_cfg_in <= k[0] ? 8'h09 : 8'h00;
      repeater_in <= k[2];
      inband_multi_in <= ~k[0];
      inband_ovr_en_in <= !k[3];
      wv = 8'($urandom) & 8'hFC | {6'h00, ctl};
      i_host.access(1'b1, device_id_in, 8'h1A, wv);
      rd(device_id_in, 8'h1A, 1, {4'h0, aux_audio_in, 1'b0, ctl}, "ctl2");
      chk("width", {7'h00, ctl[1]}, {7'h00, wide_payload_select_out});
      chk("bits", ctl[1] ? 8'h1C : 8'h18, {3'h0, payload_bits_out});
      chk("sync", {7'h00, !ctl[1]}, {7'h00, sync_ctrl_en_out});
      am = (k[2] && !k[3] ? !k[0] : ctl[0]) ? 2 : (k[0] ? 1 : 0);
      chk("audio", 8'(am), 8'(audio_mode_out));
      chk("island", 8'(am == 2), {7'h00, island_only_out});
    end
    bist_start_in <= 1'b1;
    @(posedge mclk_in);
    bist_start_in <= 1'b0;
    bist_active_in <= 1'b1;
    cnt = $urandom_range(20, 1);
    bc_crc_err_in <= 1'b1;
    repeat (cnt) @(posedge mclk_in);
    bc_crc_err_in <= 1'b0;
    rd(device_id_in, 8'h1B, 1, 8'(cnt), "errcnt");
    i_host.access(1'b1, device_id_in, 8'h1B, 8'h5A);
    rd(device_id_in, 8'h1B, 1, 8'(cnt), "errcnt ro");
    bc_crc_err_in <= 1'b1;
    repeat (300) @(posedge mclk_in);
    bc_crc_err_in <= 1'b0;
    rd(device_id_in, 8'h1B, 1, 8'hFF, "errcnt sat");
    bc_err_clear_in <= 1'b1;
    @(posedge mclk_in);
    bc_err_clear_in <= 1'b0;
    rd(device_id_in, 8'h1B, 1, 8'h00, "errcnt clr");
    bist_active_in <= 1'b0;
    bc_crc_err_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    bist_active_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    bc_crc_err_in <= 1'b0;
    rd(device_id_in, 8'h1B, 1, 8'h03, "errcnt idle");
    bist_start_in <= 1'b1;
    @(posedge mclk_in);
    bist_start_in <= 1'b0;
    rd(device_id_in, 8'h1B, 1, 8'h00, "errcnt start");
    // Every pin is treated as configured for input here
    repeat (4) begin
      pins_in <= 8'($urandom);
      repeat (3) @(posedge mclk_in);
      rd(device_id_in, 8'h1C, 1, {pins_in.aux_pin_seven,
        pins_in.aux_pin_six, pins_in.aux_pin_five, 1'b0,
        pins_in.io_pin}, "pins1");
      rd(device_id_in, 8'h1D, 1, {7'h00, pins_in.aux_pin_eight},
        "pins2");
    end
    for (int s = 0; s < 8; s++) begin
      i_host.access(1'b1, device_id_in, 8'h1E, 8'($urandom) & 8'hF8 | 8'(s));
      sel = 3'(s);
      rd(device_id_in, 8'h1E, 1, 8'(s), "portsel");
      chk("second en", {7'h00, sel[2]}, {7'h00, second_address_enable_out});
      i_host.access(1'b1, device_id_in, 8'h1A, {6'h00, ctl});
      // Second address only used once it has been enabled
      if (sel[2]) rd(device_id_in + 7'h01, 8'h1A, 1, {4'h0, aux_audio_in, 1'b0, ctl}, "second");
    end
    results();
  end
endmodule
